/* File: verilog/sbc_spi_regmap.v */
// serial control port slave with the twenty-register control map
// assumes serial mode 0 (sample on sclk rise, shift on fall), msb first;
// sclk must be slow enough that each phase spans at least 4 clock cycles
`timescale 1ns/100ps
`include "sbc_regs.vh"
module sbc_spi_regmap #(
  parameter NUM_REGS = `SBC_NUM_REGS
) (
  input wire clock,
  input wire sys_rst,
  // serial pins
  input wire spi_cs_n_pin,
  input wire spi_sclk_pin,
  input wire spi_mosi_pin,
  output wire spi_miso_out,
  output wire spi_miso_oe,
  // status and flags from the device core
  input wire [7:0] fixed_status,
  input wire [7:0] extended_status,
  input wire [7:0] can_flags,
  input wire [7:0] io_flags,
  input wire [7:0] int_flags,
  input wire [7:0] lin_channel_one_control_flags,
  input wire [3:0] device_mode_state,
  // control towards the device core
  output wire [8*NUM_REGS-1:0] ctrl_image,
  output wire write_strobe,
  output wire [4:0] write_addr,
  output wire watchdog_refresh,
  output wire lp_mode_request,
  output wire special_mode_enter,
  output wire debug_exit,
  output wire frame_error
);

  // timing summary, in system clocks:
  //   select is seen about three clocks after the pin falls
  //   each serial rise is seen two to three clocks after the pin
  //   the answer bit moves two to three clocks after a serial fall
  //   pulses follow one clock after the synchronised select rises
  // the serial clock phases must therefore last four clocks or more;
  // a faster master would sample a bit that has not yet moved

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edge detection

  wire [2:0] pins_s;
  wire cs_n_s;
  wire sclk_s;
  wire mosi_s;
  reg cs_n_d_ff;
  reg sclk_d_ff;

  // all three pins pass the same two stages, so data and clock keep
  // their relative timing after synchronisation
  sbc_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h4)
  ) u_pin_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in({spi_cs_n_pin, spi_sclk_pin, spi_mosi_pin}),
    .sync_out(pins_s)
  );

  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign mosi_s = pins_s[0];

  // delayed copies of the synchronised levels for edge finding
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cs_n_d_ff <= 1'b1;
      sclk_d_ff <= 1'b0;
    end else begin
      cs_n_d_ff <= cs_n_s;
      sclk_d_ff <= sclk_s;
    end
  end

  wire frame_start = cs_n_d_ff & ~cs_n_s;
  wire frame_end = ~cs_n_d_ff & cs_n_s;
  wire sclk_rise = ~cs_n_s & sclk_s & ~sclk_d_ff;
  wire sclk_fall = ~cs_n_s & ~sclk_s & sclk_d_ff;

  ////////////////////////////////////////////////////////////////////////
  // receive shifter and bit counter

  // the shifter is cleared at select so a short frame never mixes with
  // bits left from the previous one; the commit at frame end only looks
  // at the shifter when exactly sixteen rises were seen
  reg [15:0] rx_ff;
  reg [4:0] bit_cnt_ff;
  wire [15:0] nxt_rx = {rx_ff[14:0], mosi_s};
  // the counter saturates so over-long frames are caught at frame end
  wire [4:0] nxt_bit_cnt = (bit_cnt_ff == 5'h1f) ? bit_cnt_ff : bit_cnt_ff + 5'h01;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_ff <= 16'h0000;
      bit_cnt_ff <= 5'h00;
    end else if (frame_start) begin
      rx_ff <= 16'h0000;
      bit_cnt_ff <= 5'h00;
    end else if (sclk_rise) begin
      rx_ff <= nxt_rx;
      bit_cnt_ff <= nxt_bit_cnt;
    end
  end

  // after the eighth rise the header sits in the low byte of nxt_rx
  wire header_done = sclk_rise & (nxt_bit_cnt == 5'h08);
  wire [1:0] hdr_cmd = nxt_rx[7:6];
  wire [4:0] hdr_addr = nxt_rx[5:1];

  // committed frame fields
  wire [1:0] frm_cmd = rx_ff[`SBC_CMD_HI:`SBC_CMD_LO];
  wire [4:0] frm_addr = rx_ff[`SBC_ADDR_HI:`SBC_ADDR_LO];
  wire [7:0] frm_data = rx_ff[7:0];

  ////////////////////////////////////////////////////////////////////////
  // register storage

  // one byte per address; the refresh slot exists but is never written,
  // which keeps the image a plain array indexed by the address field
  reg [7:0] regs_ff [0:NUM_REGS-1];
  reg [7:0] lfsr_ff;
  reg [7:0] random_code_ff;
  integer i;

  // address classification: valid storage, and flag-capable interfaces
  function addr_stored;
    input [4:0] a;
    begin
      addr_stored = (a < NUM_REGS) && (a != `SBC_ADDR_WD_REFRESH);
    end
  endfunction

  function addr_has_flags;
    input [4:0] a;
    begin
      addr_has_flags = (a >= `SBC_ADDR_CAN) && (a <= `SBC_ADDR_LIN_CHANNEL_ONE_CONTROL);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // frame acceptance

  // reads never check parity: the master sets bit 8 to one on every
  // read, so a parity test there would refuse legal commands
  // parity covers all sixteen bits; an odd count of ones is correct
  wire parity_on = regs_ff[`SBC_ADDR_INIT_MISC][`SBC_MISC_PARITY_EN];
  wire parity_ok = ~parity_on | (^rx_ff);
  wire frame_full = frame_end & (bit_cnt_ff == 5'h10);
  wire do_write = frame_full & (frm_cmd == `SBC_CMD_WRITE) & parity_ok;
  wire do_read = frame_full & (frm_cmd == `SBC_CMD_READ);

  // short, long and bad-parity write frames all count as errors
  wire nxt_frame_error = frame_end & ((bit_cnt_ff != 5'h10) |
    ((frm_cmd == `SBC_CMD_WRITE) & ~parity_ok));

  ////////////////////////////////////////////////////////////////////////
  // register writes

  // only stored addresses take data; others are left untouched
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (i = 0; i < NUM_REGS; i = i + 1) begin
        regs_ff[i] <= `SBC_REG_RESET;
      end
    end else if (do_write && addr_stored(frm_addr)) begin
      // covers analog monitor, scratch, init, timers, mode, interfaces
      regs_ff[frm_addr] <= frm_data;
    end
  end

  // free running code source; never reaches zero from a nonzero seed
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lfsr_ff <= `SBC_LFSR_SEED;
    end else begin
      lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
    end
  end

  // a fresh code is drawn whenever the special mode register is read,
  // so the master cannot reuse a stale inverted code
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      random_code_ff <= `SBC_LFSR_SEED;
    end else if (header_done && hdr_cmd == `SBC_CMD_READ &&
                 hdr_addr == `SBC_ADDR_SPECIAL_MODE) begin
      random_code_ff <= lfsr_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // answer byte selection

  reg [7:0] nxt_low;

  // the low byte is latched once, at the header boundary, so core inputs
  // that move later in the frame cannot tear the answer
  // chosen at the header boundary so it is ready for the ninth bit
  always @* begin
    nxt_low = 8'h00;
    case (hdr_cmd)
      `SBC_CMD_WRITE: begin
        nxt_low = extended_status;
      end
      `SBC_CMD_READ: begin
        if (hdr_addr == `SBC_ADDR_SPECIAL_MODE) begin
          nxt_low = lfsr_ff;
        end else if (hdr_addr == `SBC_ADDR_MODE) begin
          // current mode in the high nibble, code in the low nibble
          nxt_low = {device_mode_state, random_code_ff[3:0]};
        end else if (addr_stored(hdr_addr)) begin
          nxt_low = regs_ff[hdr_addr];
        end else begin
          nxt_low = 8'h00;
        end
      end
      `SBC_CMD_FLAGS: begin
        if (addr_has_flags(hdr_addr)) begin
          case (hdr_addr)
            `SBC_ADDR_CAN: nxt_low = can_flags;
            `SBC_ADDR_IO: nxt_low = io_flags;
            `SBC_ADDR_INT: nxt_low = int_flags;
            `SBC_ADDR_LIN_CHANNEL_ONE_CONTROL: nxt_low = lin_channel_one_control_flags;
            default: nxt_low = 8'h00;
          endcase
        end else begin
          nxt_low = 8'h00;
        end
      end
      default: begin
        nxt_low = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit path

  reg [15:0] tx_ff;
  reg miso_ff;
  reg [3:0] tx_idx;

  // high byte is the fixed status caught at frame start
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_ff <= 16'h0000;
    end else if (frame_start) begin
      tx_ff <= {fixed_status, 8'h00};
    end else if (header_done) begin
      tx_ff[7:0] <= nxt_low;
    end
  end

  // index of the bit that follows the last sampled one
  always @* begin
    tx_idx = 4'hf - bit_cnt_ff[3:0];
  end

  // miso comes from a flip-flop so the pin never carries a glitch
  // first bit is placed at select; each later bit after a falling edge
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      miso_ff <= 1'b0;
    end else if (frame_start) begin
      miso_ff <= fixed_status[7];
    end else if (sclk_fall) begin
      if (bit_cnt_ff[4]) begin
        miso_ff <= 1'b0; // no daisy chain: extra clocks shift zeros
      end else begin
        miso_ff <= tx_ff[tx_idx];
      end
    end
  end

  // output is released whenever the frame is not selected
  assign spi_miso_out = miso_ff;
  assign spi_miso_oe = ~cs_n_s;

  ////////////////////////////////////////////////////////////////////////
  // side-effect pulses

  reg write_strobe_ff;
  reg [4:0] write_addr_ff;
  reg wd_refresh_ff;
  reg lp_req_ff;
  reg special_ff;
  reg debug_exit_ff;
  reg frame_error_ff;

  // pulses are decided at the synchronised select rise, never mid-frame,
  // so an aborted frame has no side effect beyond the error pulse and the fresh code drawn at a special mode read header
  // each pulse stands for one clock after the frame has closed
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      write_strobe_ff <= 1'b0;
      write_addr_ff <= 5'h00;
      wd_refresh_ff <= 1'b0;
      lp_req_ff <= 1'b0;
      special_ff <= 1'b0;
      debug_exit_ff <= 1'b0;
      frame_error_ff <= 1'b0;
    end else begin
      write_strobe_ff <= do_write & addr_stored(frm_addr);
      if (do_write) begin
        write_addr_ff <= frm_addr;
      end
      wd_refresh_ff <= do_write & (frm_addr == `SBC_ADDR_WD_REFRESH);
      lp_req_ff <= do_write & (frm_addr == `SBC_ADDR_MODE);
      // entry only when the written byte is the inverse of the drawn code
      special_ff <= do_write & (frm_addr == `SBC_ADDR_SPECIAL_MODE) &
        (frm_data == ~random_code_ff);
      // reading the mode register takes the device out of debug mode
      debug_exit_ff <= do_read & (frm_addr == `SBC_ADDR_MODE);
      frame_error_ff <= nxt_frame_error;
    end
  end

  assign write_strobe = write_strobe_ff;
  assign write_addr = write_addr_ff;
  assign watchdog_refresh = wd_refresh_ff;
  assign lp_mode_request = lp_req_ff;
  assign special_mode_enter = special_ff;
  assign debug_exit = debug_exit_ff;
  assign frame_error = frame_error_ff;

  ////////////////////////////////////////////////////////////////////////
  // control image towards the device core

  // the core sees every byte at once; no read strobe is needed because
  // the stored bytes only change together with write_strobe
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g = g + 1) begin : g_image
      assign ctrl_image[8*g+7:8*g] = regs_ff[g];
    end
  endgenerate

endmodule

/* File: verilog/sbc_regs.vh */
// register map, field positions and command codes of the serial control port
// assumes a 16-bit frame, msb first, with the command in the top two bits
`ifndef SBC_REGS_VH
`define SBC_REGS_VH

// frame layout
`define SBC_FRAME_BITS 16
`define SBC_CMD_HI 15
`define SBC_CMD_LO 14
`define SBC_ADDR_HI 13
`define SBC_ADDR_LO 9
`define SBC_PARITY_BIT 8

// command codes
`define SBC_CMD_READ 2'h0
`define SBC_CMD_WRITE 2'h1
`define SBC_CMD_RSVD 2'h2
`define SBC_CMD_FLAGS 2'h3

// register offsets
`define SBC_ADDR_ANALOG_MON 5'h00
`define SBC_ADDR_SCRATCH_A 5'h01
`define SBC_ADDR_SCRATCH_D 5'h04
`define SBC_ADDR_INIT_REG 5'h05
`define SBC_ADDR_INIT_MISC 5'h08
`define SBC_ADDR_SPECIAL_MODE 5'h09
`define SBC_ADDR_TIMER_A 5'h0a
`define SBC_ADDR_TIMER_C 5'h0c
`define SBC_ADDR_WD_REFRESH 5'h0d
`define SBC_ADDR_MODE 5'h0e
`define SBC_ADDR_REG_CTRL 5'h0f
`define SBC_ADDR_CAN 5'h10
`define SBC_ADDR_IO 5'h11
`define SBC_ADDR_INT 5'h12
`define SBC_ADDR_LIN_CHANNEL_ONE_CONTROL 5'h13
`define SBC_NUM_REGS 20

// fields and reset values
`define SBC_MISC_PARITY_EN 6
`define SBC_REG_RESET 8'h00
`define SBC_LFSR_SEED 8'h5a

`endif

/* File: verilog/sbc_sync.v */
// two flip-flop synchroniser for pin inputs
// assumes inputs are asynchronous to clock; output is safe to read by logic
`timescale 1ns/100ps
module sbc_sync #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire clock,
  input wire sys_rst,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1_ff;
  reg [WIDTH-1:0] stage2_ff;

  // first stage feeds only the second stage
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stage1_ff <= RESET_VAL;
      stage2_ff <= RESET_VAL;
    end else begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_out = stage2_ff;

endmodule

/* File: testbench/sbc_props.sv */
// checker for the serial control port register map
// assumes it is bound to sbc_spi_regmap and sees only its ports
`timescale 1ns/100ps
module sbc_props #(
  parameter NUM_REGS = 20
) (
  input wire clock,
  input wire sys_rst,
  input wire spi_cs_n_pin,
  input wire spi_sclk_pin,
  input wire spi_miso_out,
  input wire spi_miso_oe,
  input wire [8*NUM_REGS-1:0] ctrl_image,
  input wire write_strobe,
  input wire watchdog_refresh,
  input wire lp_mode_request,
  input wire debug_exit,
  input wire frame_error
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  // pin quiet for a while, and frame already over
  sequence s_cs_idle;
    spi_cs_n_pin [*4];
  endsequence
  sequence s_after_frame;
    $past(spi_cs_n_pin, 2) && spi_cs_n_pin;
  endsequence
  property p_oe_off;
    s_cs_idle |-> !spi_miso_oe;
  endproperty
  property p_oe_on;
    $fell(spi_cs_n_pin) |-> ##[2:4] spi_miso_oe;
  endproperty
  property p_img_hold;
    ctrl_image != $past(ctrl_image) |-> write_strobe;
  endproperty
  property p_strobe_pulse;
    write_strobe |=> !write_strobe;
  endproperty
  property p_pulse_late;
    (write_strobe || watchdog_refresh || lp_mode_request || debug_exit) |-> s_after_frame;
  endproperty
  property p_wd_excl;
    watchdog_refresh |-> !write_strobe && !lp_mode_request;
  endproperty
  property p_dbg_read;
    debug_exit |-> !write_strobe && !frame_error && !lp_mode_request;
  endproperty
  property p_miso_hold;
    $rose(spi_sclk_pin) |=> $stable(spi_miso_out) [*3];
  endproperty
  property p_fe_pulse;
    frame_error |=> !frame_error;
  endproperty
  // the write strobe and frame error must stay single pulses even in back-to-back frames
  a_oe_off: assert property (p_oe_off) else $error("miso driven while deselected");
  a_oe_on: assert property (p_oe_on) else $error("miso not driven after select");
  a_img_hold: assert property (p_img_hold) else $error("register changed without write");
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("write strobe too long");
  a_pulse_late: assert property (p_pulse_late) else $error("pulse before frame end");
  a_wd_excl: assert property (p_wd_excl) else $error("refresh with other pulse");
  a_dbg_read: assert property (p_dbg_read) else $error("debug exit on a write");
  a_miso_hold: assert property (p_miso_hold) else $error("miso moved while sclk high");
  a_fe_pulse: assert property (p_fe_pulse) else $error("frame error too long");
endmodule
bind sbc_spi_regmap sbc_props #(.NUM_REGS(NUM_REGS)) u_props (.clock(clock),
  .sys_rst(sys_rst), .spi_cs_n_pin(spi_cs_n_pin), .spi_sclk_pin(spi_sclk_pin),
  .spi_miso_out(spi_miso_out), .spi_miso_oe(spi_miso_oe), .ctrl_image(ctrl_image),
  .write_strobe(write_strobe), .watchdog_refresh(watchdog_refresh),
  .lp_mode_request(lp_mode_request), .debug_exit(debug_exit), .frame_error(frame_error));

/* File: testbench/sbc_master.sv */
// serial master model standing in for the microcontroller
// assumes the caller enters xfer just after a falling clock edge
`timescale 1ns/100ps
module sbc_master (
  input wire clock,
  output reg spi_cs_n_pin,
  output reg spi_sclk_pin,
  output reg spi_mosi_pin,
  input wire spi_miso_out
);
  initial begin
    spi_cs_n_pin = 1'b1;
    spi_sclk_pin = 1'b0;
    spi_mosi_pin = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // n clocks of a mode 0 frame; sclk stands still outside frames
  task xfer(input [15:0] w, input integer n, output [15:0] rx);
    integer i;
    begin
      rx = 16'h0000;
      spi_cs_n_pin = 1'b0;
      repeat (8) @(negedge clock);
      for (i = 0; i < n; i = i + 1) begin
        spi_mosi_pin = (i < 16) ? w[15-i] : 1'b0;
        repeat (4) @(negedge clock);
        spi_sclk_pin = 1'b1;
        repeat (4) @(negedge clock);
        rx = {rx[14:0], spi_miso_out}; // late sample, miso settles 2-3 clocks after fall
        spi_sclk_pin = 1'b0;
      end
      repeat (4) @(negedge clock);
      spi_cs_n_pin = 1'b1;
      spi_mosi_pin = ~spi_mosi_pin; // flipped line, no stale level
      repeat (8) @(negedge clock);
    end
  endtask
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the serial control port register map
// assumes sbc_master as the serial master and a shadow copy of the map
`timescale 1ns/100ps
module testbench;
  reg clock = 0;
  reg sys_rst = 1;
  reg [7:0] fs = 0, es = 0, cf = 0, iof = 0, itf = 0, lf = 0;
  reg [3:0] dms = 0;
  wire cs_n, sclk, mosi, miso, oe, ws, wr, lp, sm, dx, fe;
  wire [159:0] img;
  wire [4:0] wa;
  reg [5:0] pv = 0;
  reg pv_clr = 0;
  reg [4:0] la = 0;
  reg [7:0] sh [0:31];
  reg [7:0] code = 8'h5a;
  integer n_fail = 0, n_compared = 0, i, k;
  always #20 clock = ~clock;
  sbc_spi_regmap DUT (.clock(clock), .sys_rst(sys_rst), .spi_cs_n_pin(cs_n),
    .spi_sclk_pin(sclk), .spi_mosi_pin(mosi), .spi_miso_out(miso), .spi_miso_oe(oe),
    .fixed_status(fs), .extended_status(es), .can_flags(cf), .io_flags(iof),
    .int_flags(itf), .lin_channel_one_control_flags(lf), .device_mode_state(dms), .ctrl_image(img),
    .write_strobe(ws), .write_addr(wa), .watchdog_refresh(wr), .lp_mode_request(lp),
    .special_mode_enter(sm), .debug_exit(dx), .frame_error(fe));
  sbc_master M (.clock(clock), .spi_cs_n_pin(cs_n), .spi_sclk_pin(sclk),
    .spi_mosi_pin(mosi), .spi_miso_out(miso));
  // collect every pulse of one frame
  always @(posedge clock) pv <= pv_clr ? 6'h00 : pv | {fe, dx, sm, lp, wr, ws};
  ////////////////////////////////////////////////////////////
  task chk(input [15:0] s, input [15:0] e);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: saw %h want %h", $time, s, e);
      end
    end
  endtask
  task close_out;
    begin
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // expected low byte on miso for one command
  function [7:0] rdv(input [1:0] c, input [4:0] a);
    rdv = c == 2'h1 ? es : c == 2'h0 ? (a == 5'h0e ? {dms, code[3:0]} : a < 5'h14 ? sh[a] : 8'h00)
      : c == 2'h3 ? (a == 5'h10 ? cf : a == 5'h11 ? iof : a == 5'h12 ? itf : a == 5'h13 ? lf
      : 8'h00) : 8'h00;
  endfunction
  task op(input [15:0] w, input integer n);
    reg [15:0] rx;
    reg ok;
    reg [1:0] c;
    reg [4:0] a;
    reg [7:0] e;
    begin
      c = w[15:14];
      a = w[13:9];
      {fs, es, cf, iof} = $urandom;
      k = $urandom;
      {itf, lf, dms} = k[19:0];
      e = rdv(c, a);
      ok = n == 16 && c == 2'h1 && (!sh[8][6] || ^w);
      pv_clr = 1;
      @(negedge clock);
      pv_clr = 0;
      M.xfer(w, n, rx);
      repeat (4) @(negedge clock);
      if (n == 16) chk(rx[15:8], fs);
      if (n == 16 && !(c == 2'h0 && a == 5'h09)) chk(rx[7:0], e);
      if (n == 16 && c == 2'h0 && a == 5'h09) code = rx[7:0];
      chk(pv, {n != 16 || c == 2'h1 && !ok, n == 16 && c == 2'h0 && a == 5'h0e,
        ok && a == 5'h09 && w[7:0] == ~code, ok && a == 5'h0e, ok && a == 5'h0d,
        ok && a < 5'h14 && a != 5'h0d});
      if (ok && a < 5'h14 && a != 5'h0d) sh[a] = w[7:0];
      if (ok) la = a;
      chk(wa, la);
      for (k = 0; k < 20; k = k + 1) chk(img[8*k+:8], sh[k]);
    end
  endtask
  // main sequence: every code at every address, random traffic, corner cases
  initial begin
    i = $urandom(29194);
    for (i = 0; i < 32; i = i + 1) sh[i] = 8'h00;
    repeat (20) @(negedge clock);
    sys_rst = 0;
    repeat (4) @(negedge clock);
    for (i = 0; i < 128; i = i + 1) op({i[1:0], i[6:2], 1'b1, 8'h00}, 16);
    for (i = 0; i < 150; i = i + 1) begin
      k = $urandom;
      op({1'b0, k[0], k[12:8], ~k[0], k[7:0] & (k[12:8] == 5'h08 ? 8'hbf : 8'hff)}, 16);
    end
    op(16'h1300, 16);
    op({2'h1, 5'h09, 1'b0, ~code}, 16);
    op(16'h4a55, 15);
    op(16'h4a55, 17);
    op(16'h5040, 16);
    op(16'h4233, 16);
    op(16'h4333, 16);
    op(16'h5100, 16);
    close_out;
  end
  // about 300 frames of some 160 clocks each
  initial begin
    #(40 * 60000);
    n_fail = n_fail + 1;
    close_out;
  end
endmodule
